// >>> adcsq_defines.vh
// constants for the converter sequencer: register offsets, fields, reset values, timing
// assumes inclusion by bare name from the sequencer design files
`ifndef ADCSQ_DEFINES_VH
`define ADCSQ_DEFINES_VH
// register indices; offsets are word indices, so byte address is index * 4
`define ADCSQ_IDX_PIN_LOW 12'hf48
`define ADCSQ_IDX_PIN_HIGH 12'hf49
`define ADCSQ_IDX_CTRL_FIRST 12'hf4a
`define ADCSQ_IDX_CTRL_SECOND 12'hf4b
`define ADCSQ_IDX_RES_HIGH 12'hf4c
`define ADCSQ_IDX_RES_LOW 12'hf4d
`define ADCSQ_IDX_FLAGS 12'hf4e
`define ADCSQ_IDX_MODE 12'hf4f
// control fields
`define ADCSQ_CF_ON 0
`define ADCSQ_CF_GO 1
`define ADCSQ_CF_NREF 7
`define ADCSQ_CF_PREF 6
`define ADCSQ_PH_BGEN 7
`define ADCSQ_PH_RSVD 6
`define ADCSQ_FL_DONE 0
`define ADCSQ_FL_IRQEN 1
// reset values
`define ADCSQ_RST_PIN_LOW 8'h00
`define ADCSQ_RST_PIN_HIGH 8'h00
`define ADCSQ_RST_CTRL 8'h00
// timing in bit periods
`define ADCSQ_CONV_10 5'd11
`define ADCSQ_CONV_12 5'd13
`define ADCSQ_WAIT_AFTER 5'd2
// internal rc bit period and its cycle count at 100 ns
`define ADCSQ_RC_PERIOD_NS 4000
`define ADCSQ_CLK_NS 100
// sized for the divider compare; equals rc period over clock period
`define ADCSQ_RC_CYCLES 7'd40
`endif

// >>> adcsq_tick.v
// bit period tick generator from divided system clock or internal rc timebase
// assumes the select field comes from a register on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "adcsq_defines.vh"
module adcsq_tick (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // control
  input wire run,
  input wire [2:0] clk_sel,
  // tick out
  output reg tick
);
  reg [6:0] cnt_r;
  reg [6:0] div;
  always @* begin
    case (clk_sel)
      3'h0: div = 7'd2;
      3'h1: div = 7'd8;
      3'h2: div = 7'd32;
      3'h3: div = `ADCSQ_RC_CYCLES;
      3'h4: div = 7'd4;
      3'h5: div = 7'd16;
      default: div = 7'd64;
    endcase
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 7'h00;
      tick <= 1'b0;
    end else if (!run) begin
      cnt_r <= 7'h00;
      tick <= 1'b0;
    end else if (cnt_r == div - 7'd1) begin
      cnt_r <= 7'h00;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 7'd1;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> adcsq_sar.v
// successive approximation search, one bit decided per bit period
// assumes comparator input is already synchronised
`timescale 1ns/100ps
`default_nettype none
module adcsq_sar (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // control
  input wire start,
  input wire step,
  input wire cmp_hi,
  // state
  output reg [11:0] trial,
  output reg [11:0] bit_r
);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trial <= 12'h000;
      bit_r <= 12'h000;
    end else if (start) begin
      trial <= 12'h800;
      bit_r <= 12'h800;
    end else if (step && bit_r != 12'h000) begin
      trial <= ((cmp_hi ? trial : (trial & ~bit_r)) | (bit_r >> 1));
      bit_r <= bit_r >> 1;
    end
  end
endmodule
`default_nettype wire

// >>> adcsq_top.v
// converter sequencer with pin configuration, reference select and ahb-lite registers
// assumes a single ahb-lite master; analog comparator result arrives asynchronously
// Notes on behaviour
// (RL1) low config bits: one digital, zero analog
// (RL2) high config bits cover channels eight-twelve
// (RL3) band-gap bit requests reference power
// (RL4) software keeps reserved bit zero
// (RL5) references selectable: rails or external pins
// (RL6) sleep conversions only with rc clock
// (RL7) result found by successive approximation
// (RL8) finish loads result, clears go, sets flag
// (RL9) reset clears registers and aborts conversion
// (RL10) result pair untouched by reset
// (RL11) two bit periods wait after conversion
// (RL12) conversion start opens sampling switch
// (RL13) zero acquisition field converts immediately
// (RL14) nonzero field samples programmed periods first
// (RL15) sampling resumes after completion
// (RL16) go stays set through both phases
// (RL17) software configures, starts, waits, reads
// (RL18) software allows acquisition after channel change
// (RL19) acquisition codes 0,2,4,6,8,12,16,20 periods
// (RL20) clock codes select divisors or rc
// (RL21) eleven or thirteen periods per conversion
// (RL22) clearing go aborts, result unchanged
// (RL23) all phases counted on one tick
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "adcsq_defines.vh"
module adcsq_top (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // analog side
  input wire cmp_hi_async,
  input wire sleep_mode,
  output reg [12:0] pin_digital_select,
  output reg bandgap_power_request,
  output reg vref_pos_ext,
  output reg vref_neg_ext,
  output reg [3:0] channel_sel,
  output reg sample_switch_closed,
  output reg [11:0] dac_trial,
  output reg conversion_irq
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ACQ = 3'd1;
  localparam ST_CONV = 3'd2;
  localparam ST_WAIT = 3'd3;
  reg [7:0] pin_low_r, pin_high_r, ctrl_first_r, ctrl_second_r;
  reg [7:0] res_high_r, res_low_r;
  reg done_flag_r, irq_en_r, mode10_r;
  reg [2:0] state_r;
  reg [2:0] state_r_nxt;
  reg [4:0] cnt_r;
  reg cmp_s1_r, cmp_s2_r, sleep_s1_r, sleep_s2_r;
  reg ph_wr_r;
  reg [11:0] ph_addr_r;
  wire tick;
  wire [11:0] trial;
  wire [11:0] sar_bit;
  wire on = ctrl_first_r[`ADCSQ_CF_ON];
  wire go = ctrl_first_r[`ADCSQ_CF_GO];
  wire [2:0] acq_sel = ctrl_second_r[5:3];
  wire [2:0] clk_sel = ctrl_second_r[2:0];
  wire rc_sel = (clk_sel == 3'h3);
  // sleep halts the sequencer unless the rc timebase is chosen
  wire run = on && go && !(sleep_s2_r && !rc_sel); // [RL6]
  wire wr_data = ph_wr_r;
  wire go_wr = wr_data && ph_addr_r == `ADCSQ_IDX_CTRL_FIRST;
  wire go_new = go_wr && hwdata[`ADCSQ_CF_GO];
  wire abort = go_wr && !hwdata[`ADCSQ_CF_GO]; // [RL22]
  wire conv_len_last;
  reg [4:0] acq_len;
  always @* begin
    case (acq_sel)
      3'h0: acq_len = 5'd0;
      3'h1: acq_len = 5'd2;
      3'h2: acq_len = 5'd4;
      3'h3: acq_len = 5'd6;
      3'h4: acq_len = 5'd8;
      3'h5: acq_len = 5'd12;
      3'h6: acq_len = 5'd16;
      default: acq_len = 5'd20;
    endcase // [RL19]
  end
  assign conv_len_last = (cnt_r == (mode10_r ? `ADCSQ_CONV_10 : `ADCSQ_CONV_12) - 5'd1); // [RL21]
  wire finish = state_r == ST_CONV && tick && conv_len_last && !abort;
  adcsq_tick u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    // divider restarts with each sequence so phases are whole bit periods
    .run(on && state_r_nxt != ST_IDLE && !(sleep_s2_r && !rc_sel)),
    .clk_sel(clk_sel), // [RL20]
    .tick(tick) // [RL23]
  );
  adcsq_sar u_sar (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(state_r != ST_CONV && state_r_nxt == ST_CONV),
    .step(state_r == ST_CONV && tick),
    .cmp_hi(cmp_s2_r),
    .trial(trial), // [RL7]
    .bit_r(sar_bit)
  );
  always @* begin
    state_r_nxt = state_r;
    case (state_r)
      ST_IDLE: if (go_new && on) state_r_nxt = (acq_len == 5'd0) ? ST_CONV : ST_ACQ; // [RL13] [RL14]
      ST_ACQ: if (abort) state_r_nxt = ST_WAIT;
        else if (run && tick && cnt_r == acq_len - 5'd1) state_r_nxt = ST_CONV;
      ST_CONV: if (abort || finish) state_r_nxt = ST_WAIT;
      ST_WAIT: if (tick && cnt_r == `ADCSQ_WAIT_AFTER - 5'd1) state_r_nxt = ST_IDLE; // [RL11]
      default: state_r_nxt = ST_IDLE;
    endcase
    if (!on) state_r_nxt = ST_IDLE;
  end
  // synchronisers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_s1_r <= 1'b0;
      cmp_s2_r <= 1'b0;
      sleep_s1_r <= 1'b0;
      sleep_s2_r <= 1'b0;
    end else begin
      cmp_s1_r <= cmp_hi_async;
      cmp_s2_r <= cmp_s1_r;
      sleep_s1_r <= sleep_mode;
      sleep_s2_r <= sleep_s1_r;
    end
  end
  // sequencer and registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
      cnt_r <= 5'd0;
      pin_low_r <= `ADCSQ_RST_PIN_LOW; // [RL9]
      pin_high_r <= `ADCSQ_RST_PIN_HIGH;
      ctrl_first_r <= `ADCSQ_RST_CTRL;
      ctrl_second_r <= `ADCSQ_RST_CTRL;
      done_flag_r <= 1'b0;
      irq_en_r <= 1'b0;
      mode10_r <= 1'b0;
    end else begin
      state_r <= state_r_nxt;
      if (state_r_nxt != state_r) cnt_r <= 5'd0;
      else if (tick && state_r != ST_IDLE) cnt_r <= cnt_r + 5'd1;
      if (wr_data) begin
        if (ph_addr_r == `ADCSQ_IDX_PIN_LOW) pin_low_r <= hwdata[7:0]; // [RL1]
        else if (ph_addr_r == `ADCSQ_IDX_PIN_HIGH) pin_high_r <= hwdata[7:0] & 8'hdf; // [RL2] [RL3]
        else if (ph_addr_r == `ADCSQ_IDX_CTRL_FIRST) ctrl_first_r <= hwdata[7:0]; // [RL5]
        else if (ph_addr_r == `ADCSQ_IDX_CTRL_SECOND) ctrl_second_r <= hwdata[7:0];
        else if (ph_addr_r == `ADCSQ_IDX_MODE) mode10_r <= hwdata[0];
        if (ph_addr_r == `ADCSQ_IDX_FLAGS) irq_en_r <= hwdata[`ADCSQ_FL_IRQEN];
      end
      // completion set wins over a software clear in the same cycle
      if (finish) begin
        ctrl_first_r[`ADCSQ_CF_GO] <= 1'b0; // [RL8] [RL16]
        done_flag_r <= 1'b1;
      end else if (wr_data && ph_addr_r == `ADCSQ_IDX_FLAGS) begin
        done_flag_r <= hwdata[`ADCSQ_FL_DONE];
      end
      if (!on && state_r != ST_IDLE) ctrl_first_r[`ADCSQ_CF_GO] <= 1'b0;
    end
  end
  // result pair has no reset so its content survives any reset [RL10]
  always @(posedge hclk) begin
    if (finish) begin
      res_high_r <= {4'h0, trial[11:8]};
      res_low_r <= trial[7:0];
    end else if (wr_data && ph_addr_r == `ADCSQ_IDX_RES_HIGH) res_high_r <= hwdata[7:0];
    else if (wr_data && ph_addr_r == `ADCSQ_IDX_RES_LOW) res_low_r <= hwdata[7:0];
  end
  // ahb-lite: zero wait states, okay always
  wire [11:0] rd_idx = haddr[13:2];
  reg [7:0] rd_val;
  always @* begin
    if (rd_idx == `ADCSQ_IDX_PIN_LOW) rd_val = pin_low_r;
    else if (rd_idx == `ADCSQ_IDX_PIN_HIGH) rd_val = pin_high_r;
    else if (rd_idx == `ADCSQ_IDX_CTRL_FIRST) rd_val = ctrl_first_r;
    else if (rd_idx == `ADCSQ_IDX_CTRL_SECOND) rd_val = ctrl_second_r;
    else if (rd_idx == `ADCSQ_IDX_RES_HIGH) rd_val = res_high_r;
    else if (rd_idx == `ADCSQ_IDX_RES_LOW) rd_val = res_low_r;
    else if (rd_idx == `ADCSQ_IDX_FLAGS) rd_val = {6'h00, irq_en_r, done_flag_r};
    else if (rd_idx == `ADCSQ_IDX_MODE) rd_val = {7'h00, mode10_r};
    else rd_val = 8'h00;
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_r <= 1'b0;
      ph_addr_r <= 12'h000;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      ph_wr_r <= hsel && hready && htrans[1] && hwrite;
      if (hsel && hready && htrans[1]) ph_addr_r <= haddr[13:2];
      if (hsel && hready && htrans[1] && !hwrite) hrdata <= {24'h000000, rd_val};
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
  // analog-facing outputs
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_digital_select <= 13'h0000;
      bandgap_power_request <= 1'b0;
      vref_pos_ext <= 1'b0;
      vref_neg_ext <= 1'b0;
      channel_sel <= 4'h0;
      sample_switch_closed <= 1'b0;
      dac_trial <= 12'h000;
      conversion_irq <= 1'b0;
    end else begin
      pin_digital_select <= {pin_high_r[4:0], pin_low_r};
      bandgap_power_request <= pin_high_r[`ADCSQ_PH_BGEN];
      vref_pos_ext <= ctrl_first_r[`ADCSQ_CF_PREF];
      vref_neg_ext <= ctrl_first_r[`ADCSQ_CF_NREF];
      channel_sel <= ctrl_first_r[5:2];
      // open for conversion, settling wait and while off, closed (sampling) otherwise
      sample_switch_closed <= on && state_r_nxt != ST_CONV && state_r_nxt != ST_WAIT; // [RL12] [RL15]
      dac_trial <= trial;
      conversion_irq <= done_flag_r && irq_en_r;
    end
  end
endmodule
`default_nettype wire

// >>> adcsq_sva.sv
// port checker for the converter sequencer
// assumes bind onto adcsq_top with one ahb-lite master
`timescale 1ns/100ps
`default_nettype none
module adcsq_sva (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  // analog side
  input wire [12:0] pin_digital_select,
  input wire bandgap_power_request,
  input wire vref_pos_ext,
  input wire vref_neg_ext,
  input wire [3:0] channel_sel,
  input wire sample_switch_closed,
  input wire [11:0] dac_trial,
  input wire conversion_irq
);
  reg wr_r;
  reg [11:0] wa_r;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // write data phase marker, so checks look two edges past hwdata
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r <= 1'b0;
      wa_r <= 12'h000;
    end else if (hready) begin
      wr_r <= hsel && htrans[1] && hwrite;
      wa_r <= haddr[13:2];
    end
  end
  a_pin_low: assert property (
    wr_r && wa_r == 12'hf48 |-> ##2 pin_digital_select[7:0] == $past(hwdata[7:0], 2))
    else $error("pin low config wrong");
  a_pin_high: assert property (
    wr_r && wa_r == 12'hf49 |-> ##2 pin_digital_select[12:8] == $past(hwdata[4:0], 2)
    && bandgap_power_request == $past(hwdata[7], 2)) else $error("pin high config wrong");
  a_ref_chan: assert property (
    wr_r && wa_r == 12'hf4a |-> ##2
    {vref_neg_ext, vref_pos_ext, channel_sel} == $past(hwdata[7:2], 2))
    else $error("reference or channel wrong");
  a_reset_clear: assert property (
    $rose(hresetn) |-> pin_digital_select == 13'h0000 && !bandgap_power_request
    && channel_sel == 4'h0 && !conversion_irq) else $error("outputs not cleared by reset");
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not ready okay");
  a_irq_set: assert property (
    wr_r && wa_r == 12'hf4e && hwdata[1:0] == 2'h3 |-> ##[1:2] conversion_irq)
    else $error("flag with enable gave no irq");
  a_irq_mask: assert property (
    wr_r && wa_r == 12'hf4e && !hwdata[1] |-> ##2 !conversion_irq)
    else $error("masked irq still high");
  a_trial_open: assert property (
    $changed(dac_trial) |-> !sample_switch_closed || !$past(sample_switch_closed))
    else $error("trial moved while sampling");
  a_open_min: assert property (
    $fell(sample_switch_closed) |=> !sample_switch_closed [*3])
    else $error("switch reclosed too soon");
endmodule
bind adcsq_top adcsq_sva chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hreadyout, .hresp, .pin_digital_select, .bandgap_power_request, .vref_pos_ext,
  .vref_neg_ext, .channel_sel, .sample_switch_closed, .dac_trial, .conversion_irq);
`default_nettype wire

// >>> adc_sequencer_and_pin_config_tb.sv
// self-checking bench for the converter sequencer
// assumes the dut is the only slave, its hreadyout is the bus hready
`timescale 1ns/100ps
`default_nettype none
`include "adcsq_defines.vh"
module adc_sequencer_and_pin_config_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic cmp_hi_async = 1'b0;
  logic sleep_mode = 1'b0;
  logic mon_rd = 1'b0;
  logic [11:0] vin = 12'h0;
  logic [7:0] r8;
  wire [31:0] hrdata;
  wire hreadyout, hresp, bandgap_power_request, vref_pos_ext, vref_neg_ext;
  wire sample_switch_closed, conversion_irq;
  wire [12:0] pin_digital_select;
  wire [3:0] channel_sel;
  wire [11:0] dac_trial;
  logic [31:0] exp_q[$];
  string nm_q[$];
  int errors = 0;
  int n_checks = 0;
  int seed = 71164;
  int i, ta, to, t0;
  int ap[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  int dv[8] = '{2, 8, 32, `ADCSQ_RC_CYCLES, 4, 16, 64, 64};
  logic [11:0] ra[6] = '{12'hf48, 12'hf49, 12'hf4a, 12'hf4b, 12'hf4e, 12'hf4f};
  adcsq_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cmp_hi_async, .sleep_mode,
    .pin_digital_select, .bandgap_power_request, .vref_pos_ext, .vref_neg_ext, .channel_sel,
    .sample_switch_closed, .dac_trial, .conversion_irq);
  initial forever #50 hclk = ~hclk;
  // comparator of an ideal input level against the trial code
  always @(posedge hclk) cmp_hi_async <= (vin >= dac_trial);
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  always @(posedge hclk) begin
    if (mon_rd && hreadyout === 1'b1) chk(nm_q.pop_front(), hrdata, exp_q.pop_front());
  end
  task automatic bus(bit w, logic [11:0] a, logic [31:0] d, string nm);
    hsel <= 1'b1;
    haddr <= {18'h0, a, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    mon_rd <= !w;
    if (!w) begin
      exp_q.push_back(d);
      nm_q.push_back(nm);
    end
    do @(posedge hclk); while (hreadyout !== 1'b1);
    mon_rd <= 1'b0;
  endtask
  task automatic wr(logic [11:0] a, logic [7:0] d);
    bus(1'b1, a, {24'h0, d}, "");
  endtask
  task automatic rd(logic [11:0] a, logic [7:0] e, string nm);
    bus(1'b0, a, {24'h0, e}, nm);
  endtask
  // sampled on the falling edge so the edge's updates have landed
  task automatic conv(logic [2:0] acq, logic [2:0] ck, output int ta, output int to);
    vin = $random(seed);
    wr(12'hf4b, {2'h0, acq, ck});
    wr(12'hf4a, 8'hc7);
    to = 0;
    do begin @(negedge hclk); to++; end while (sample_switch_closed !== 1'b0);
    ta = to;
    do begin @(negedge hclk); to++; end while (sample_switch_closed !== 1'b1);
    to = to - ta;
    @(posedge hclk);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #2000000;
    errors++;
    print_verdict();
  end
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (ra[k]) rd(ra[k], 8'h00, "reset value");
    r8 = $random(seed);
    wr(12'hf48, r8);
    rd(12'hf48, r8, "pin low");
    wr(12'hf49, ~r8 & 8'hbf);
    rd(12'hf49, ~r8 & 8'h9f, "pin high");
    wr(12'hf50, 8'h5a);
    rd(12'hf50, 8'h00, "unmapped");
    wr(12'hf4e, 8'h03);
    wr(12'hf4e, 8'h01);
    wr(12'hf4e, 8'h02);
    wr(12'hf4f, 8'h01);
    wr(12'hf4a, 8'hc5);
    for (i = 0; i < 8; i++) begin
      sleep_mode <= (i == 3);
      conv(3'h0, i[2:0], ta, to);
      chk("clock span", to, 13 * dv[i]);
      wr(12'hf4e, 8'h02);
    end
    wr(12'hf4f, 8'h00);
    for (i = 0; i < 8; i++) begin
      conv(i[2:0], 3'h1, ta, to);
      if (i == 0) t0 = ta;
      chk("acq time", ta - t0, ap[i] * dv[1]);
      chk("conv span", to, 15 * dv[1]);
      chk("irq", conversion_irq, 1'b1);
      rd(12'hf4c, {4'h0, vin[11:8]}, "result high");
      rd(12'hf4d, vin[7:0], "result low");
      rd(12'hf4e, 8'h03, "flags");
      rd(12'hf4a, 8'hc5, "go cleared");
      wr(12'hf4e, 8'h02);
    end
    sleep_mode <= 1'b1;
    wr(12'hf4b, 8'h00);
    wr(12'hf4a, 8'hc7);
    repeat (200) @(posedge hclk);
    rd(12'hf4a, 8'hc7, "halted go");
    wr(12'hf4a, 8'hc5);
    sleep_mode <= 1'b0;
    rd(12'hf4c, {4'h0, vin[11:8]}, "abort keeps high");
    rd(12'hf4d, vin[7:0], "abort keeps low");
    wr(12'hf4b, 8'h06);
    wr(12'hf4a, 8'hc7);
    repeat (30) @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(12'hf4a, 8'h00, "ctrl after reset");
    rd(12'hf48, 8'h00, "pins after reset");
    rd(12'hf4c, {4'h0, vin[11:8]}, "reset keeps high");
    rd(12'hf4d, vin[7:0], "reset keeps low");
    print_verdict();
  end
endmodule
`default_nettype wire
